//--- rtl/board_irq_pkg.sv
// Constants and carrier types for the board interrupt and reset logic
package board_irq_pkg;

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;

  localparam logic [11:0] OFS_NMI_SEL_A   = 12'h0140;
  localparam logic [11:0] OFS_NMI_SEL_B   = 12'h0150;
  localparam logic [11:0] OFS_NMI_STAT_A  = 12'h0160;
  localparam logic [11:0] OFS_NMI_STAT_B  = 12'h0170;
  localparam logic [11:0] OFS_MASK        = 12'h0180;
  localparam logic [11:0] OFS_CLR_TIMEOUT = 12'h0190;
  localparam logic [11:0] OFS_CLR_TIMER   = 12'h01A0;
  localparam logic [11:0] OFS_IRQA_SEL    = 12'h0200;
  localparam logic [11:0] OFS_IRQB_SEL    = 12'h0210;
  localparam logic [11:0] OFS_IRQA_STAT   = 12'h0220;
  localparam logic [11:0] OFS_IRQB_STAT   = 12'h0230;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int NSA_UART1   = 0;
  localparam int NSA_UART2   = 1;
  localparam int NSA_PRT     = 2;
  localparam int NSA_ISA     = 3;
  localparam int NSA_W       = 4;
  localparam int NSB_EXT     = 0;
  localparam int NSB_TIMEOUT = 1;
  localparam int NSB_TIMER   = 2;
  localparam int NSB_W       = 3;
  localparam int MSK_NMI     = 0;
  localparam int MSK_IRQA    = 1;
  localparam int MSK_IRQB    = 2;
  localparam int MSK_W       = 3;
  localparam int IA_UART1    = 0;
  localparam int IA_ISA      = 1;
  localparam int IA_PRT      = 2;
  localparam int IA_W        = 3;
  localparam int IB_TIMER    = 0;
  localparam int IB_TIMEOUT  = 1;
  localparam int IB_W        = 2;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [NSA_W-1:0] NSA_RESET  = 4'h0;
  localparam logic [NSB_W-1:0] NSB_RESET  = 3'h0;
  localparam logic [MSK_W-1:0] MSK_RESET  = 3'h0;
  localparam logic [IA_W-1:0]  IA_RESET   = 3'h0;
  localparam logic [IB_W-1:0]  IB_RESET   = 2'h0;
  localparam int               TIMEOUT_CLKS = 1024;
  localparam int               SYNC_W       = 12;

  // ----------------------------------------------------------------
  // Carriers, all active high after pin conversion
  // ----------------------------------------------------------------
  typedef struct packed {
    logic romem_rst;
    logic rear_sw;
    logic socket_sw;
    logic isa_rst;
  } rst_src_t;

  typedef struct packed {
    logic uart1;
    logic uart2;
    logic prt;
    logic isa_com;
    logic timer;
    logic ext;
    logic romem_nmi;
    logic nmi_push_switch;
  } irq_src_t;

  typedef enum logic [1:0] {
    TO_IDLE,
    TO_COUNT,
    TO_WAIT_END
  } timeout_state_t;

endpackage : board_irq_pkg

//--- rtl/board_irq_reset.sv
// Board interrupt routing, ready time-out and reset generation
`timescale 1ns/1ps
module board_irq_reset #(
  parameter int TIMEOUT_CLKS = board_irq_pkg::TIMEOUT_CLKS
) (
  input  wire logic                            i_clk,
  input  wire logic                            i_resetn,
  input  wire logic [board_irq_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [board_irq_pkg::DATA_W-1:0] i_wr_data,
  input  wire logic                            i_wr,
  input  wire logic                            i_rd,
  output logic      [board_irq_pkg::DATA_W-1:0] o_rd_data,
  input  wire logic                            i_uart1_irq,
  input  wire logic                            i_uart2_irq,
  input  wire logic                            i_prt_irq,
  input  wire logic                            i_isa_com_irq,
  input  wire logic                            i_timer_out,
  input  wire logic                            i_ext_irq_n,
  input  wire logic                            i_romem_nmi_n,
  input  wire logic                            i_nmi_push_switch,
  input  wire logic                            i_romem_reset_n,
  input  wire logic                            i_rear_reset_switch,
  input  wire logic                            i_socket_reset_switch,
  input  wire logic                            i_isa_reset_req,
  input  wire logic                            i_bus_cycle_active,
  output logic                                 o_nmi,
  output logic                                 o_maskable_irq_a,
  output logic                                 o_maskable_irq_b,
  output logic                                 o_cpu_ext_irq_n,
  output logic                                 o_cpu_reset_n,
  output logic                                 o_ext_reset_n,
  output logic                                 o_force_ready,
  output logic                                 o_timeout_led
);

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  board_irq_pkg::rst_src_t rst_raw;
  board_irq_pkg::irq_src_t irq_raw;
  board_irq_pkg::rst_src_t rst_s;
  board_irq_pkg::irq_src_t irq_s;
  logic [board_irq_pkg::SYNC_W-1:0] sync_out;

  always_comb begin
    rst_raw.romem_rst = ~i_romem_reset_n;
    rst_raw.rear_sw   = i_rear_reset_switch;
    rst_raw.socket_sw = i_socket_reset_switch;
    rst_raw.isa_rst   = i_isa_reset_req;
    irq_raw.uart1     = i_uart1_irq;
    irq_raw.uart2     = i_uart2_irq;
    irq_raw.prt       = i_prt_irq;
    irq_raw.isa_com   = i_isa_com_irq;
    irq_raw.timer     = i_timer_out;
    irq_raw.ext       = ~i_ext_irq_n;
    irq_raw.romem_nmi = ~i_romem_nmi_n;
    irq_raw.nmi_push_switch    = i_nmi_push_switch;
  end

  input_sync3 #(
    .WIDTH (board_irq_pkg::SYNC_W)
  ) u_sync (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_async  ({rst_raw, irq_raw}),
    .o_sync   (sync_out)
  );

  assign {rst_s, irq_s} = sync_out;

  // ----------------------------------------------------------------
  // Reset generation
  // ----------------------------------------------------------------
  logic board_clr_reg;
  logic cpu_reset_n_reg;

  // Any reset source holds the CPU and clears the board registers
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      board_clr_reg   <= 1'b1;
      cpu_reset_n_reg <= 1'b0;
    end else begin
      board_clr_reg   <= |rst_s;
      cpu_reset_n_reg <= ~(|rst_s);
    end
  end

  assign o_cpu_reset_n = cpu_reset_n_reg;
  assign o_ext_reset_n = cpu_reset_n_reg;

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [board_irq_pkg::ADDR_W-1:0] a,
                               input logic [board_irq_pkg::ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  logic [board_irq_pkg::NSA_W-1:0] nmi_sel_a_reg;
  logic [board_irq_pkg::NSB_W-1:0] nmi_sel_b_reg;
  logic [board_irq_pkg::MSK_W-1:0] block_reg;
  logic [board_irq_pkg::IA_W-1:0]  irqa_sel_reg;
  logic [board_irq_pkg::IB_W-1:0]  irqb_sel_reg;
  logic                            clr_timeout;
  logic                            clr_timer;

  assign clr_timeout = i_wr & hit(i_addr, board_irq_pkg::OFS_CLR_TIMEOUT);
  assign clr_timer   = i_wr & hit(i_addr, board_irq_pkg::OFS_CLR_TIMER);

  // Select registers; all three bits of select port B are writable, higher write data bits are dropped
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      nmi_sel_a_reg <= board_irq_pkg::NSA_RESET;
      nmi_sel_b_reg <= board_irq_pkg::NSB_RESET;
      irqa_sel_reg  <= board_irq_pkg::IA_RESET;
      irqb_sel_reg  <= board_irq_pkg::IB_RESET;
    end else if (board_clr_reg) begin
      nmi_sel_a_reg <= board_irq_pkg::NSA_RESET;
      nmi_sel_b_reg <= board_irq_pkg::NSB_RESET;
      irqa_sel_reg  <= board_irq_pkg::IA_RESET;
      irqb_sel_reg  <= board_irq_pkg::IB_RESET;
    end else if (i_wr) begin
      if (hit(i_addr, board_irq_pkg::OFS_NMI_SEL_A)) begin
        nmi_sel_a_reg <= i_wr_data[board_irq_pkg::NSA_W-1:0];
      end
      if (hit(i_addr, board_irq_pkg::OFS_NMI_SEL_B)) begin
        nmi_sel_b_reg <= i_wr_data[board_irq_pkg::NSB_W-1:0];
      end
      if (hit(i_addr, board_irq_pkg::OFS_IRQA_SEL)) begin
        irqa_sel_reg <= i_wr_data[board_irq_pkg::IA_W-1:0];
      end
      if (hit(i_addr, board_irq_pkg::OFS_IRQB_SEL)) begin
        irqb_sel_reg <= i_wr_data[board_irq_pkg::IB_W-1:0];
      end
    end
  end

  // Final block bits for the three outputs
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      block_reg <= board_irq_pkg::MSK_RESET;
    end else if (board_clr_reg) begin
      block_reg <= board_irq_pkg::MSK_RESET;
    end else if (i_wr && hit(i_addr, board_irq_pkg::OFS_MASK)) begin
      block_reg <= i_wr_data[board_irq_pkg::MSK_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Ready time-out
  // ----------------------------------------------------------------
  localparam int CNT_W = $clog2(TIMEOUT_CLKS + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(TIMEOUT_CLKS - 1);

  board_irq_pkg::timeout_state_t to_state_reg;
  logic [CNT_W-1:0]              to_cnt_reg;
  logic                          force_ready_reg;
  logic                          timeout_req_reg;

  // Counts one continuous bus cycle; fires once, then waits for the cycle to end
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      to_state_reg    <= board_irq_pkg::TO_IDLE;
      to_cnt_reg      <= '0;
      force_ready_reg <= 1'b0;
    end else begin
      force_ready_reg <= 1'b0;
      case (to_state_reg)
        board_irq_pkg::TO_IDLE: begin
          to_cnt_reg <= '0;
          if (i_bus_cycle_active) begin
            to_state_reg <= board_irq_pkg::TO_COUNT;
            to_cnt_reg   <= CNT_W'(1);
          end
        end
        board_irq_pkg::TO_COUNT: begin
          if (!i_bus_cycle_active) begin
            to_state_reg <= board_irq_pkg::TO_IDLE;
            to_cnt_reg   <= '0;
          end else if (to_cnt_reg == CNT_LAST) begin
            to_state_reg    <= board_irq_pkg::TO_WAIT_END;
            force_ready_reg <= 1'b1;
          end else begin
            to_cnt_reg <= to_cnt_reg + CNT_W'(1);
          end
        end
        board_irq_pkg::TO_WAIT_END: begin
          if (!i_bus_cycle_active) begin
            to_state_reg <= board_irq_pkg::TO_IDLE;
            to_cnt_reg   <= '0;
          end
        end
        default: begin
          to_state_reg <= board_irq_pkg::TO_IDLE;
        end
      endcase
    end
  end

  assign o_force_ready = force_ready_reg;

  // Latched time-out request; a new event wins over a clear in the same cycle
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      timeout_req_reg <= 1'b0;
    end else if (force_ready_reg) begin
      timeout_req_reg <= 1'b1;
    end else if (clr_timeout || board_clr_reg) begin
      timeout_req_reg <= 1'b0;
    end
  end

  assign o_timeout_led = timeout_req_reg;

  // ----------------------------------------------------------------
  // Interval timer latch
  // ----------------------------------------------------------------
  logic timer_prev_reg;
  logic timer_req_reg;
  logic timer_rise;

  assign timer_rise = irq_s.timer & ~timer_prev_reg;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      timer_prev_reg <= 1'b0;
    end else begin
      timer_prev_reg <= irq_s.timer;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      timer_req_reg <= 1'b0;
    end else if (timer_rise) begin
      timer_req_reg <= 1'b1;
    end else if (clr_timer || board_clr_reg) begin
      timer_req_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Raw status and routing
  // ----------------------------------------------------------------
  logic [board_irq_pkg::NSA_W-1:0] stat_a;
  logic [board_irq_pkg::NSB_W-1:0] stat_b;
  logic [board_irq_pkg::IA_W-1:0]  stat_irqa;
  logic [board_irq_pkg::IB_W-1:0]  stat_irqb;

  always_comb begin
    stat_a = '0;
    stat_b = '0;
    stat_irqa = '0;
    stat_irqb = '0;
    stat_a[board_irq_pkg::NSA_UART1]   = irq_s.uart1;
    stat_a[board_irq_pkg::NSA_UART2]   = irq_s.uart2;
    stat_a[board_irq_pkg::NSA_PRT]     = irq_s.prt;
    stat_a[board_irq_pkg::NSA_ISA]     = irq_s.isa_com;
    stat_b[board_irq_pkg::NSB_EXT]     = irq_s.ext;
    stat_b[board_irq_pkg::NSB_TIMEOUT] = timeout_req_reg;
    stat_b[board_irq_pkg::NSB_TIMER]   = timer_req_reg;
    stat_irqa[board_irq_pkg::IA_UART1] = irq_s.uart1;
    stat_irqa[board_irq_pkg::IA_ISA]   = irq_s.isa_com;
    stat_irqa[board_irq_pkg::IA_PRT]   = irq_s.prt;
    stat_irqb[board_irq_pkg::IB_TIMER]   = timer_req_reg;
    stat_irqb[board_irq_pkg::IB_TIMEOUT] = timeout_req_reg;
  end

  logic nmi_reg;
  logic irq_a_reg;
  logic irq_b_reg;
  logic ext_irq_n_reg;

  // Enabled sources OR the fixed NMI sources (NMI only), then the block bit, then a flip-flop
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      nmi_reg   <= 1'b0;
      irq_a_reg <= 1'b0;
      irq_b_reg <= 1'b0;
    end else begin
      nmi_reg   <= ~block_reg[board_irq_pkg::MSK_NMI] &
                   ((|(stat_a & nmi_sel_a_reg)) |
                    (|(stat_b & nmi_sel_b_reg)) |
                    irq_s.romem_nmi | irq_s.nmi_push_switch);
      irq_a_reg <= ~block_reg[board_irq_pkg::MSK_IRQA] &
                   (|(stat_irqa & irqa_sel_reg));
      irq_b_reg <= ~block_reg[board_irq_pkg::MSK_IRQB] &
                   (|(stat_irqb & irqb_sel_reg));
    end
  end

  // Buffered copy of the expansion interrupt toward the CPU input
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ext_irq_n_reg <= 1'b1;
    end else begin
      ext_irq_n_reg <= ~irq_s.ext;
    end
  end

  assign o_nmi            = nmi_reg;
  assign o_maskable_irq_a = irq_a_reg;
  assign o_maskable_irq_b = irq_b_reg;
  assign o_cpu_ext_irq_n  = ext_irq_n_reg;

  // ----------------------------------------------------------------
  // Read port: data stands only in the cycle after the strobe
  // ----------------------------------------------------------------
  localparam int DATA_W = board_irq_pkg::DATA_W;

  logic [board_irq_pkg::DATA_W-1:0] rd_next;
  logic [board_irq_pkg::DATA_W-1:0] rd_data_reg;

  always_comb begin
    rd_next = '0;
    if (i_rd) begin
      case (i_addr)
        board_irq_pkg::OFS_NMI_SEL_A:  rd_next = DATA_W'(nmi_sel_a_reg);
        board_irq_pkg::OFS_NMI_SEL_B:  rd_next = DATA_W'(nmi_sel_b_reg);
        board_irq_pkg::OFS_NMI_STAT_A: rd_next = DATA_W'(stat_a);
        board_irq_pkg::OFS_NMI_STAT_B: rd_next = DATA_W'(stat_b);
        board_irq_pkg::OFS_MASK:       rd_next = DATA_W'(block_reg);
        board_irq_pkg::OFS_IRQA_SEL:   rd_next = DATA_W'(irqa_sel_reg);
        board_irq_pkg::OFS_IRQB_SEL:   rd_next = DATA_W'(irqb_sel_reg);
        board_irq_pkg::OFS_IRQA_STAT:  rd_next = DATA_W'(stat_irqa);
        board_irq_pkg::OFS_IRQB_STAT:  rd_next = DATA_W'(stat_irqb);
        default:                       rd_next = '0;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rd_data_reg <= '0;
    end else begin
      rd_data_reg <= rd_next;
    end
  end

  assign o_rd_data = rd_data_reg;

endmodule : board_irq_reset

//--- rtl/input_sync3.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module input_sync3 #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clk,
  input  wire logic             i_resetn,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      logic out_reg;

      always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          s3_reg <= 1'b0;
        end else begin
          s1_reg <= i_async[g];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
        end
      end

      // A change is accepted once stages two and three agree
      always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
          out_reg <= 1'b0;
        end else if (s2_reg == s3_reg) begin
          out_reg <= s3_reg;
        end
      end

      assign o_sync[g] = out_reg;
    end
  endgenerate

endmodule : input_sync3

//--- tb/board_irq_reset_bench.sv
// Self-checking bench for the board interrupt and reset logic
`timescale 1ns/1ps
module board_irq_reset_bench;
  localparam int TO = 8;
  logic        clk, rstn, wr, rd, go, tol, tml;
  logic [11:0] addr;
  logic [7:0]  wdata, rdata;
  logic        u1, u2, pr, isa, tmr, extn, romn, nsw, romrn, rrear, rsock, risa, bus;
  logic        nmi, ia, ib, cext, crst, erst, fr, led;
  logic [15:0] len;
  logic [7:0]  m [12];
  logic [7:0]  wm [12];
  logic [11:0] ofs [12];
  logic [3:0]  sta;
  logic [2:0]  stb, ias;
  logic [1:0]  ibs;
  logic [31:0] seed;
  int          num_errors = 0, checks = 0, cyc = 0;

  board_irq_reset #(.TIMEOUT_CLKS(TO)) board_irq_reset_inst (
    .i_clk(clk), .i_resetn(rstn), .i_addr(addr), .i_wr_data(wdata), .i_wr(wr),
    .i_rd(rd), .o_rd_data(rdata), .i_uart1_irq(u1), .i_uart2_irq(u2), .i_prt_irq(pr),
    .i_isa_com_irq(isa), .i_timer_out(tmr), .i_ext_irq_n(extn), .i_romem_nmi_n(romn),
    .i_nmi_push_switch(nsw), .i_romem_reset_n(romrn), .i_rear_reset_switch(rrear),
    .i_socket_reset_switch(rsock), .i_isa_reset_req(risa), .i_bus_cycle_active(bus),
    .o_nmi(nmi), .o_maskable_irq_a(ia), .o_maskable_irq_b(ib), .o_cpu_ext_irq_n(cext),
    .o_cpu_reset_n(crst), .o_ext_reset_n(erst), .o_force_ready(fr), .o_timeout_led(led));
  cpu_bus_model cpu_bus_model_inst (.i_clk(clk), .i_resetn(rstn), .i_go(go), .i_len(len),
    .i_force_ready(fr), .o_bus_cycle_active(bus));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      $display("ERROR %0t run did not finish", $time);
      give_verdict();
    end
  end
  // ----------------------------------------
  // Reference model and checks
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic void upd();
    sta = {isa, pr, u2, u1};
    stb = {tml, tol, ~extn};
    ias = {pr, isa, u1};
    ibs = {tol, tml};
  endfunction : upd
  function automatic logic [7:0] exp_rd(input int k);
    upd();
    case (k)
      2: return {4'h0, sta};
      3: return {5'h00, stb};
      9: return {5'h00, ias};
      10: return {6'h00, ibs};
      default: return m[k];
    endcase
  endfunction : exp_rd
  function automatic logic [7:0] exp_pin();
    logic n, a, b;
    upd();
    n = !m[4][0] && ((|(m[0][3:0] & sta)) || (|(m[1][2:0] & stb)) || !romn || nsw);
    a = !m[4][1] && (|(m[7][2:0] & ias));
    b = !m[4][2] && (|(m[8][1:0] & ibs));
    return {3'h0, n, a, b, extn, tol};
  endfunction : exp_pin
  task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t read %h expected %h", $time, got, exp);
    end
  endtask : chk_rd
  task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t pins %b expected %b", $time, got, exp);
    end
  endtask : chk_pin
  task automatic give_verdict();
    if (num_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  // ----------------------------------------
  // Register bus master
  // ----------------------------------------
  task automatic wr_reg(input int k, input logic [7:0] d);
    addr <= ofs[k];
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
    m[k] = d & wm[k];
    if (k == 5) tol = 1'b0;
    if (k == 6) tml = 1'b0;
  endtask : wr_reg
  task automatic rd_all();
    for (int k = 0; k < 12; k++) begin
      addr <= ofs[k];
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk_rd(rdata, exp_rd(k));
      @(posedge clk);
    end
  endtask : rd_all
  task automatic check_pins();
    repeat (10) @(posedge clk);
    #1;
    chk_pin({3'h0, nmi, ia, ib, cext, led}, exp_pin());
  endtask : check_pins
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    ofs = '{board_irq_pkg::OFS_NMI_SEL_A, board_irq_pkg::OFS_NMI_SEL_B,
      board_irq_pkg::OFS_NMI_STAT_A, board_irq_pkg::OFS_NMI_STAT_B, board_irq_pkg::OFS_MASK,
      board_irq_pkg::OFS_CLR_TIMEOUT, board_irq_pkg::OFS_CLR_TIMER, board_irq_pkg::OFS_IRQA_SEL,
      board_irq_pkg::OFS_IRQB_SEL, board_irq_pkg::OFS_IRQA_STAT, board_irq_pkg::OFS_IRQB_STAT,
      12'h0300};
    wm = '{8'h0f, 8'h07, 8'h00, 8'h00, 8'h07, 8'h00, 8'h00, 8'h07, 8'h03, 8'h00, 8'h00, 8'h00};
    m = '{default: 8'h00};
    {wr, rd, go, rstn, tol, tml} = 6'h00;
    {u1, u2, pr, isa, tmr, nsw, rrear, rsock, risa} = 9'h000;
    {extn, romn, romrn} = 3'h7;
    addr = 12'h000;
    wdata = 8'h00;
    len = 16'h0000;
    seed = 32'h294e_9193;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 60; i++) begin
      seed = lfsr(seed);
      if (seed[1] && !tmr) tml = 1'b1;
      {u1, u2, pr, isa, tmr, extn} <= seed[5:0];
      nsw <= seed[9] & seed[10];
      romn <= seed[7] | seed[8];
      check_pins();
      rd_all();
      wr_reg(int'(seed[19:16]) % 12, seed[31:24]);
      wr_reg(int'(seed[23:20]) % 12, seed[15:8]);
    end
    {u1, u2, pr, isa, tmr, nsw} <= 6'h00;
    {romn, extn} <= 2'b11;
    wr_reg(1, 8'h02);
    wr_reg(8, 8'h02);
    wr_reg(4, 8'h00);
    len <= 16'hffff;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    for (int w = 0; w < TO + 20 && fr !== 1'b1; w++) begin
      @(posedge clk);
      #1;
    end
    chk_pin({7'h00, fr}, 8'h01);
    tol = 1'b1;
    check_pins();
    wr_reg(4, 8'h07);
    check_pins();
    rd_all();
    wr_reg(5, 8'h00);
    wr_reg(4, 8'h00);
    check_pins();
    len <= 16'(TO - 1);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (TO + 4) @(posedge clk);
    check_pins();
    for (int j = 0; j < 4; j++) begin
      wr_reg(0, 8'h0f);
      {romrn, risa, rrear, rsock} <= 4'h8 ^ (4'h1 << j);
      repeat (10) @(posedge clk);
      #1;
      chk_pin({6'h00, crst, erst}, 8'h00);
      {romrn, risa, rrear, rsock} <= 4'h8;
      m = '{default: 8'h00};
      {tol, tml} = 2'b00;
      check_pins();
      chk_pin({6'h00, crst, erst}, 8'h03);
      rd_all();
    end
    give_verdict();
  end
endmodule : board_irq_reset_bench

//--- tb/board_irq_reset_props.sv
// Port checks on the board interrupt and reset logic
`timescale 1ns/1ps
module board_irq_reset_props #(
  parameter int TIMEOUT_CLKS = 1024
) (
  input wire logic        i_clk,
  input wire logic        i_resetn,
  input wire logic [11:0] i_addr,
  input wire logic [7:0]  i_wr_data,
  input wire logic        i_wr,
  input wire logic        i_ext_irq_n,
  input wire logic        i_romem_reset_n,
  input wire logic        i_rear_reset_switch,
  input wire logic        i_socket_reset_switch,
  input wire logic        i_isa_reset_req,
  input wire logic        i_bus_cycle_active,
  input wire logic        o_nmi,
  input wire logic        o_maskable_irq_a,
  input wire logic        o_maskable_irq_b,
  input wire logic        o_cpu_ext_irq_n,
  input wire logic        o_cpu_reset_n,
  input wire logic        o_ext_reset_n,
  input wire logic        o_force_ready,
  input wire logic        o_timeout_led
);
  logic [15:0] run_reg;
  logic        mwr;
  // ----------------------------------------
  // Length of the open bus cycle
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn)
      run_reg <= 16'h0000;
    else if (!i_bus_cycle_active)
      run_reg <= 16'h0000;
    else if (run_reg != 16'hffff)
      run_reg <= run_reg + 16'h0001;
  end
  assign mwr = i_wr && i_addr == board_irq_pkg::OFS_MASK && o_cpu_reset_n;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // Block bit lands one edge after the write, the output flop one edge later
  AST_NMI_BLOCK: assert property (mwr && i_wr_data[0] |-> ##2 !o_nmi)
    else $error("nmi passed a set block bit");
  AST_IRQA_BLOCK: assert property (mwr && i_wr_data[1] |-> ##2 !o_maskable_irq_a)
    else $error("line a passed a set block bit");
  AST_IRQB_BLOCK: assert property (mwr && i_wr_data[2] |-> ##2 !o_maskable_irq_b)
    else $error("line b passed a set block bit");
  AST_TO_FIRE: assert property (
    i_bus_cycle_active && run_reg == 16'(TIMEOUT_CLKS - 1) |=> o_force_ready)
    else $error("time-out pulse missing");
  AST_TO_CAUSE: assert property (o_force_ready |-> run_reg == 16'(TIMEOUT_CLKS))
    else $error("time-out pulse at wrong count");
  AST_TO_LATCH: assert property (o_force_ready |=> !o_force_ready && o_timeout_led)
    else $error("time-out not latched");
  AST_RST_OUT: assert property (
    (i_isa_reset_req || i_rear_reset_switch || i_socket_reset_switch || !i_romem_reset_n) [*8]
    |-> !o_cpu_reset_n && !o_ext_reset_n) else $error("reset source ignored");
  AST_EXT_BUF: assert property (
    $stable(i_ext_irq_n) [*8] |-> o_cpu_ext_irq_n == i_ext_irq_n)
    else $error("expansion interrupt not passed");
endmodule : board_irq_reset_props
bind board_irq_reset board_irq_reset_props #(.TIMEOUT_CLKS(TIMEOUT_CLKS))
  board_irq_reset_props_inst (.*);

//--- tb/cpu_bus_model.sv
// Bus cycle side of the host CPU core, prompt or stalling
`timescale 1ns/1ps
module cpu_bus_model (
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_go,
  input  wire logic [15:0] i_len,
  input  wire logic        i_force_ready,
  output logic             o_bus_cycle_active
);
  logic [15:0] left_reg;
  // ----------------------------------------
  // One cycle of i_len clocks, cut short by a forced ready
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_bus_cycle_active <= 1'b0;
      left_reg           <= 16'h0000;
    end else if (i_go) begin
      o_bus_cycle_active <= 1'b1;
      left_reg           <= i_len;
    end else if (o_bus_cycle_active) begin
      left_reg <= left_reg - 16'h0001;
      if (i_force_ready || left_reg == 16'h0001)
        o_bus_cycle_active <= 1'b0;
    end
  end
endmodule : cpu_bus_model
